// File: msr_field_model.sv
// Model of the muting sensors and the guard device
`timescale 1ns/100ps
module msr_field_model (
  input  wire logic [2:0] i_phase,
  input  wire logic       i_guard_req,
  output logic            o_first_pair_sensor_one,
  output logic            o_first_pair_sensor_two,
  output logic            o_second_pair_sensor_one,
  output logic            o_second_pair_sensor_two,
  output logic            o_guard_free
);
  always_comb
  begin
    o_first_pair_sensor_one  = i_phase inside {3'h1, 3'h2, 3'h4};
    o_first_pair_sensor_two  = i_phase inside {3'h1, 3'h2};
    o_second_pair_sensor_one = i_phase inside {3'h2, 3'h3};
    o_second_pair_sensor_two = i_phase inside {3'h2, 3'h3};
    o_guard_free             = i_guard_req;
  end
endmodule : msr_field_model

// File: msr_muting_checker_sva.sv
// Port checker for the muting supervisor
`timescale 1ns/100ps
module msr_muting_checker (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_run,
  input wire logic i_first_pair_sensor_one,
  input wire logic i_first_pair_sensor_two,
  input wire logic i_second_pair_sensor_one,
  input wire logic i_second_pair_sensor_two,
  input wire logic i_guard_free,
  input wire logic i_override,
  input wire logic i_override_enable,
  input wire logic i_other_error,
  input wire logic o_bypass,
  input wire logic o_release,
  input wire logic o_mute_status,
  input wire logic o_mute_error,
  input wire logic o_error_flag,
  input wire logic o_override_required
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  logic run_r;
  wire logic fa = i_first_pair_sensor_one & i_first_pair_sensor_two;
  wire logic sb = i_second_pair_sensor_one & i_second_pair_sensor_two;
  wire logic any_s = i_first_pair_sensor_one | i_first_pair_sensor_two
    | i_second_pair_sensor_one | i_second_pair_sensor_two;
  wire logic go_ok = fa | (i_override & i_override_enable);
  wire logic end_ok = ~sb | ~i_run;
  wire logic st = i_ce & i_run & ~run_r;
  // Run seen at the last enabled edge, like the design
  always_ff @(posedge i_sys_clk)
    if (!i_rst_n)
      run_r <= 1'b0;
    else if (i_ce)
      run_r <= i_run;
  sequence s_err_hold;
    i_ce && i_run && i_other_error && o_mute_error;
  endsequence
  a_err_release:
    assert property (o_mute_error |-> !o_release) else $error("release high");
  a_flag_error:
    assert property (o_error_flag == o_mute_error) else $error("flag differs");
  a_status_def:
    assert property (o_mute_status == (o_bypass && !o_mute_error))
      else $error("status wrong");
  a_bypass_rise:
    assert property ($rose(o_bypass) |-> $past(go_ok))
      else $error("bypass without pair");
  a_bypass_fall:
    assert property ($fell(o_bypass) |-> o_mute_error || $past(end_ok)
      || (o_override_required && $past(!i_override)))
      else $error("bypass ended early");
  a_stop_clear:
    assert property (i_ce && !i_run |=> !o_bypass && !o_release
      && !o_mute_error) else $error("stop not clean");
  a_start_free:
    assert property (st && i_guard_free && !any_s && !i_other_error
      |=> o_release) else $error("free start no release");
  a_start_blocked:
    assert property (st && !i_guard_free && !any_s |=> !o_release
      && !o_bypass) else $error("blocked start");
  a_override_req:
    assert property (st && !i_guard_free && any_s && i_override_enable
      |=> o_override_required) else $error("override not required");
  a_error_hold:
    assert property (s_err_hold |=> o_mute_error) else $error("error lost");
endmodule : msr_muting_checker

// File: msr_muting_supervisor.sv
// Four-sensor time-controlled muting supervisor with start-up handling
// Behaviour
// R1: Start with guard free, sensors idle: normal muting on correct sequence.
// R2: Start with guard free, sensors active: sensors must clear before guard drops.
// R3: Same start, guard dropped: override needed before sensors all clear.
// R4: Start with guard blocked, sensors idle: muting blocked until guard free.
// R5: Start blocked, sensors active: require override, else override-time error.
// R6: Muting error on simultaneity, total time, direction, sequence, gap faults.
// R7: Error clears only after one complete valid muting or override cycle; the code also clears it whenever i_run is low.
// R8: Clearing drops muting error only when no other error pending.
// R9: Muting error forces release low and error flag high.
// R10: Bypass starts once both first-pair sensors are active.
// R11: Bypass ends when the second pair becomes free.
// R12: Muting error output high whenever any muting error exists.
// R13: Release high without error on muting, override or free guard.
// R14: Status high during error-free muting or override, else low.
// R15: All inputs sampled once per cycle; machine evaluated synchronously.
// R16: Stop-to-run edge resets; initial state chosen from first run sample.
`timescale 1ns/100ps
module msr_muting_supervisor
  import msr_pkg::*;
#(
  parameter int unsigned SIMUL_LIM = SIMUL_CYC,
  parameter int unsigned TOTAL_LIM = TOTAL_CYC,
  parameter int unsigned OVR_LIM   = OVR_CYC,
  parameter int unsigned GAP_LIM   = GAP_CYC
)(
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  input  wire logic i_ce,
  input  wire logic i_run,
  input  wire logic i_first_pair_sensor_one,
  input  wire logic i_first_pair_sensor_two,
  input  wire logic i_second_pair_sensor_one,
  input  wire logic i_second_pair_sensor_two,
  input  wire logic i_guard_free,
  input  wire logic i_override,
  input  wire logic i_override_enable,
  input  wire logic i_other_error,
  output logic      o_bypass,
  output logic      o_release,
  output logic      o_mute_status,
  output logic      o_mute_error,
  output logic      o_error_flag,
  output logic      o_override_required
);

  msr_state_e        state_r, state_nxt;
  logic [CNT_W-1:0]  tmr_r, tmr_nxt;
  logic [CNT_W-1:0]  gap_r, gap_nxt;
  logic              err_r, err_nxt;
  logic              clr_ok_r, clr_ok_nxt;
  logic              bypass_nxt, release_nxt, status_nxt, ovr_req_nxt;

  logic a1, a2, b1, b2, pa, pb, any_s, all_s, part_a, part_b;
  assign a1     = i_first_pair_sensor_one;
  assign a2     = i_first_pair_sensor_two;
  assign b1     = i_second_pair_sensor_one;
  assign b2     = i_second_pair_sensor_two;
  assign pa     = a1 & a2;
  assign pb     = b1 & b2;
  assign any_s  = a1 | a2 | b1 | b2;
  assign all_s  = pa & pb;
  assign part_a = a1 ^ a2;
  assign part_b = b1 ^ b2;

  logic [ERR_W-1:0] fault;

  always_comb
  begin
    state_nxt   = state_r;
    tmr_nxt     = tmr_r + 1'b1;
    gap_nxt     = '0;
    err_nxt     = err_r;
    clr_ok_nxt  = clr_ok_r;
    fault       = '0;
    case (state_r)
      MSR_STOP:
      begin
        tmr_nxt = '0;
        // R16: choose start state
        if (i_run)
        begin
          // R1: guard free, idle sensors
          if (i_guard_free && !any_s)
            state_nxt = MSR_IDLE;
          // R2: sensors must clear first
          else if (i_guard_free)
            state_nxt = MSR_CLEAR_WAIT;
          // R4: block until guard free
          else if (!any_s)
            state_nxt = MSR_BLOCKED;
          // R5: override needed
          else
            state_nxt = MSR_OVR_REQ;
        end
      end
      MSR_BLOCKED:
        if (i_guard_free)
          state_nxt = MSR_IDLE;
      MSR_CLEAR_WAIT:
      begin
        if (!any_s)
          state_nxt = i_guard_free ? MSR_IDLE : MSR_BLOCKED;
        // R3: guard dropped, override path
        else if (!i_guard_free)
          state_nxt = MSR_OVR_REQ;
      end
      MSR_OVR_REQ:
      begin
        if (!any_s)
          state_nxt = i_guard_free ? MSR_IDLE : MSR_BLOCKED;
        else if (i_override && i_override_enable)
        begin
          state_nxt = MSR_OVR_ACTIVE;
          tmr_nxt   = '0;
        end
      end
      MSR_OVR_ACTIVE:
      begin
        // R5: override time exceeded
        if (tmr_r >= CNT_W'(OVR_LIM))
        begin
          fault[ERR_TOTAL] = 1'b1;
        end
        else if (!any_s)
        begin
          // R7: override cycle complete
          clr_ok_nxt = 1'b1;
          state_nxt  = MSR_IDLE;
        end
        else if (!i_override)
          state_nxt = MSR_OVR_REQ;
      end
      MSR_IDLE:
      begin
        tmr_nxt = '0;
        if (!any_s && i_guard_free)
          clr_ok_nxt = 1'b1;
        // R10: first pair starts bypass
        if (pa && !b1 && !b2)
          state_nxt = MSR_FIRST_PAIR;
        else if (part_a && (b1 | b2))
          fault[ERR_DIR] = 1'b1;
        else if (pb && !a1 && !a2)
          fault[ERR_DIR] = 1'b1;
        else if (part_a || part_b)
        begin
          tmr_nxt = tmr_r + 1'b1;
          if (tmr_r >= CNT_W'(SIMUL_LIM))
            fault[ERR_SIMUL] = 1'b1;
        end
      end
      MSR_FIRST_PAIR:
      begin
        if (all_s)
          state_nxt = MSR_ALL_FOUR;
        else if (!pa)
        begin
          gap_nxt = gap_r + 1'b1;
          if (gap_r >= CNT_W'(GAP_LIM))
            fault[ERR_GAP] = 1'b1;
        end
        if (tmr_r >= CNT_W'(TOTAL_LIM))
          fault[ERR_TOTAL] = 1'b1;
      end
      MSR_ALL_FOUR:
      begin
        if (!pa && pb)
          state_nxt = MSR_SECOND_PAIR;
        else if (!pb)
          fault[ERR_SEQ] = 1'b1;
        if (tmr_r >= CNT_W'(TOTAL_LIM))
          fault[ERR_TOTAL] = 1'b1;
      end
      MSR_SECOND_PAIR:
      begin
        // R11: second pair free ends bypass
        if (!any_s)
        begin
          state_nxt = MSR_IDLE;
          // R7: valid cycle after clean start
          // R8: other error keeps it pending
          if (clr_ok_r && !i_other_error)
            err_nxt = 1'b0;
          clr_ok_nxt = 1'b0;
        end
        else if (a1 | a2)
          fault[ERR_SEQ] = 1'b1;
        else if (!pb)
        begin
          gap_nxt = gap_r + 1'b1;
          if (gap_r >= CNT_W'(GAP_LIM))
            fault[ERR_GAP] = 1'b1;
        end
        if (tmr_r >= CNT_W'(TOTAL_LIM))
          fault[ERR_TOTAL] = 1'b1;
      end
      MSR_ERROR:
      begin
        tmr_nxt = '0;
        if (!any_s && i_guard_free)
        begin
          clr_ok_nxt = 1'b1;
          state_nxt  = MSR_IDLE;
        end
        else if (any_s && i_override && i_override_enable)
          state_nxt = MSR_OVR_ACTIVE;
      end
      default:
        state_nxt = MSR_STOP;
    endcase
    // R7: override completion clears error
    // R8: only without other pending error
    if (state_r == MSR_OVR_ACTIVE && state_nxt == MSR_IDLE &&
        !i_other_error)
      err_nxt = 1'b0;
    // R6: any fault latches error
    if (|fault)
    begin
      err_nxt    = 1'b1;
      clr_ok_nxt = 1'b0;
      state_nxt  = MSR_ERROR;
    end
    if (!i_run)
    begin
      state_nxt = MSR_STOP;
      err_nxt   = 1'b0;
    end
    bypass_nxt  = (state_nxt == MSR_FIRST_PAIR) ||
                  (state_nxt == MSR_ALL_FOUR) ||
                  (state_nxt == MSR_SECOND_PAIR) ||
                  (state_nxt == MSR_OVR_ACTIVE);
    ovr_req_nxt = (state_nxt == MSR_OVR_REQ) ||
                  (state_nxt == MSR_ERROR && any_s);
    // R14: status only without error
    status_nxt  = bypass_nxt && !err_nxt;
    // R9: error forces release low
    // R13: release on muting or free guard
    release_nxt = !(err_nxt || i_other_error) && (state_nxt != MSR_STOP) &&
                  (bypass_nxt || i_guard_free);
  end

  // R15: synchronous evaluation on each cycle with i_ce high
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      state_r             <= MSR_STOP;
      tmr_r               <= '0;
      gap_r               <= '0;
      err_r               <= 1'b0;
      clr_ok_r            <= 1'b0;
      o_bypass            <= 1'b0;
      o_release           <= 1'b0;
      o_mute_status       <= 1'b0;
      o_mute_error        <= 1'b0;
      o_error_flag        <= 1'b0;
      o_override_required <= 1'b0;
    end
    else if (i_ce)
    begin
      state_r             <= state_nxt;
      tmr_r               <= tmr_nxt;
      gap_r               <= gap_nxt;
      err_r               <= err_nxt;
      clr_ok_r            <= clr_ok_nxt;
      o_bypass            <= bypass_nxt;
      o_release           <= release_nxt;
      o_mute_status       <= status_nxt;
      // R12: error output mirrors latch
      o_mute_error        <= err_nxt;
      // R9: error flag follows error
      o_error_flag        <= err_nxt;
      o_override_required <= ovr_req_nxt;
    end
  end

endmodule : msr_muting_supervisor

// File: msr_muting_supervisor_tb_top.sv
// Testbench for the muting supervisor
`timescale 1ns/100ps
module msr_muting_supervisor_tb_top;
  logic i_sys_clk = 0, i_rst_n = 0, run = 0, guard = 1, ovr = 0, oth = 0;
  logic ce = 1, oen = 1;
  logic [2:0] phase = 3'h0;
  logic fp_one, fp_two, sp_one, sp_two, gfree;
  logic byp, rel, stat, err, flag, oreq;
  int bad_count = 0, num_checks = 0, cyc = 0;
  initial forever #12.5 i_sys_clk = ~i_sys_clk;
  msr_field_model u_msr_field_model (.i_phase(phase), .i_guard_req(guard),
    .o_first_pair_sensor_one(fp_one), .o_first_pair_sensor_two(fp_two),
    .o_second_pair_sensor_one(sp_one), .o_second_pair_sensor_two(sp_two),
    .o_guard_free(gfree));
  msr_muting_supervisor #(.SIMUL_LIM(8), .TOTAL_LIM(40), .OVR_LIM(40),
    .GAP_LIM(4)) u_msr_muting_supervisor (.i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n), .i_ce(ce), .i_run(run),
    .i_first_pair_sensor_one(fp_one), .i_first_pair_sensor_two(fp_two),
    .i_second_pair_sensor_one(sp_one), .i_second_pair_sensor_two(sp_two),
    .i_guard_free(gfree), .i_override(ovr), .i_override_enable(oen),
    .i_other_error(oth), .o_bypass(byp), .o_release(rel),
    .o_mute_status(stat), .o_mute_error(err), .o_error_flag(flag),
    .o_override_required(oreq));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test
  always @(posedge i_sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic chk(input logic got, input logic exp, input string m);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask : tick
  task automatic go(input logic [2:0] p, input int n);
    @(posedge i_sys_clk) phase <= p;
    tick(n);
  endtask : go
  task automatic restart(input logic g, input logic [2:0] p);
    @(posedge i_sys_clk) run <= 0;
    go(3'h0, 1);
    @(posedge i_sys_clk) guard <= g;
    go(p, 1);
    @(posedge i_sys_clk) run <= 1;
    tick(2);
  endtask : restart
  task automatic valid_cycle();
    go(3'h1, 2);
    go(3'h2, 2);
    go(3'h3, 2);
    go(3'h0, 3);
  endtask : valid_cycle
  task automatic t_normal();
    restart(1, 3'h0);
    chk(rel, 1, "release idle");
    go(3'h1, 2);
    chk(byp, 1, "bypass start");
    chk(stat, 1, "status on");
    go(3'h2, 2);
    go(3'h3, 2);
    chk(byp, 1, "bypass held");
    go(3'h0, 2);
    chk(byp, 0, "bypass end");
    chk(stat, 0, "status off");
    $display("done normal");
  endtask : t_normal
  task automatic t_dir();
    restart(1, 3'h0);
    go(3'h3, 2);
    chk(err, 1, "direction error");
    chk(rel, 0, "release low");
    chk(flag, 1, "flag high");
    @(posedge i_sys_clk) oth <= 1;
    go(3'h0, 3);
    valid_cycle();
    chk(err, 1, "error pending");
    @(posedge i_sys_clk) oth <= 0;
    valid_cycle();
    chk(err, 0, "error cleared");
    $display("done direction");
  endtask : t_dir
  task automatic t_simul();
    restart(1, 3'h0);
    go(3'h4, 12);
    chk(err, 1, "simultaneity error");
    @(posedge i_sys_clk) run <= 0;
    tick(2);
    chk(err, 0, "stop clears");
    $display("done simultaneity");
  endtask : t_simul
  task automatic t_blocked();
    restart(0, 3'h0);
    chk(rel, 0, "blocked release");
    go(3'h1, 3);
    chk(byp, 0, "blocked bypass");
    go(3'h0, 1);
    @(posedge i_sys_clk) guard <= 1;
    tick(3);
    chk(rel, 1, "guard free release");
    $display("done blocked");
  endtask : t_blocked
  task automatic t_ovr();
    restart(0, 3'h1);
    chk(oreq, 1, "override required");
    @(posedge i_sys_clk) ovr <= 1;
    tick(3);
    chk(byp, 1, "override bypass");
    chk(stat, 1, "override status");
    go(3'h0, 1);
    @(posedge i_sys_clk) ovr <= 0;
    tick(3);
    chk(byp, 0, "override end");
    $display("done override");
  endtask : t_ovr
  task automatic t_clear();
    restart(1, 3'h1);
    chk(byp, 0, "start pair ignored");
    chk(oreq, 0, "no override yet");
    go(3'h0, 2);
    go(3'h1, 2);
    chk(byp, 1, "muting after clear");
    restart(1, 3'h1);
    @(posedge i_sys_clk) guard <= 0;
    tick(2);
    chk(oreq, 1, "override awaited");
    @(posedge i_sys_clk) oen <= 0;
    @(posedge i_sys_clk) ovr <= 1;
    tick(3);
    chk(byp, 0, "override not enabled");
    @(posedge i_sys_clk) oen <= 1;
    tick(2);
    chk(byp, 1, "override bypass");
    go(3'h0, 2);
    chk(byp, 0, "override end");
    @(posedge i_sys_clk) ovr <= 0;
    @(posedge i_sys_clk) guard <= 1;
    @(posedge i_sys_clk) ce <= 0;
    go(3'h1, 3);
    chk(byp, 0, "frozen by enable");
    @(posedge i_sys_clk) ce <= 1;
    tick(2);
    chk(byp, 1, "bypass after enable");
    $display("done start clear");
  endtask : t_clear
  initial
  begin
    repeat (6) @(posedge i_sys_clk);
    i_rst_n <= 1;
    t_normal();
    t_dir();
    t_simul();
    t_blocked();
    t_ovr();
    t_clear();
    end_of_test();
  end
endmodule : msr_muting_supervisor_tb_top
bind msr_muting_supervisor msr_muting_checker u_msr_muting_checker (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_run(i_run),
  .i_first_pair_sensor_one(i_first_pair_sensor_one),
  .i_first_pair_sensor_two(i_first_pair_sensor_two),
  .i_second_pair_sensor_one(i_second_pair_sensor_one),
  .i_second_pair_sensor_two(i_second_pair_sensor_two),
  .i_guard_free(i_guard_free), .i_override(i_override),
  .i_override_enable(i_override_enable), .i_other_error(i_other_error),
  .o_bypass(o_bypass), .o_release(o_release),
  .o_mute_status(o_mute_status), .o_mute_error(o_mute_error),
  .o_error_flag(o_error_flag), .o_override_required(o_override_required));

// File: msr_pkg.sv
// Constants and types for the muting supervisor
package msr_pkg;
  // Default timing figures, in milliseconds
  localparam int unsigned SYS_CLK_HZ        = 40_000_000;
  localparam int unsigned SIMUL_TIME_MS     = 3000;
  localparam int unsigned TOTAL_MUTE_MS     = 60000;
  localparam int unsigned OVERRIDE_MAX_MS   = 60000;
  localparam int unsigned GAP_TIME_MS       = 100;
  localparam int unsigned MS_PER_S          = 1000;
  // Cycle counts, exact products of time and clocks per millisecond
  localparam int unsigned SIMUL_CYC =
    SIMUL_TIME_MS * (SYS_CLK_HZ / MS_PER_S);
  localparam int unsigned TOTAL_CYC =
    TOTAL_MUTE_MS * (SYS_CLK_HZ / MS_PER_S);
  localparam int unsigned OVR_CYC   =
    OVERRIDE_MAX_MS * (SYS_CLK_HZ / MS_PER_S);
  localparam int unsigned GAP_CYC   =
    GAP_TIME_MS * (SYS_CLK_HZ / MS_PER_S);
  localparam int unsigned CNT_W     = 32;

  // Error cause bit positions
  localparam int unsigned ERR_SIMUL = 0;
  localparam int unsigned ERR_TOTAL = 1;
  localparam int unsigned ERR_DIR   = 2;
  localparam int unsigned ERR_SEQ   = 3;
  localparam int unsigned ERR_GAP   = 4;
  localparam int unsigned ERR_W     = 5;

  typedef enum logic [3:0] {
    MSR_STOP,
    MSR_IDLE,
    MSR_BLOCKED,
    MSR_CLEAR_WAIT,
    MSR_OVR_REQ,
    MSR_OVR_ACTIVE,
    MSR_FIRST_PAIR,
    MSR_ALL_FOUR,
    MSR_SECOND_PAIR,
    MSR_ERROR
  } msr_state_e;
endpackage : msr_pkg
